// [common/uexp_regs.svh]
`ifndef UEXP_REGS_SVH
`define UEXP_REGS_SVH

// The program cycle is paced by the measurement strobe, one sample per cycle.
`define UEXP_CLK_HZ        40000000
`define UEXP_CYCLE_MS      5

// Hysteresis of the pick-up element, in percent of the active threshold.
`define UEXP_HYST_PCT      64'sh61
`define UEXP_PCT_DIV       64'sh64
`define UEXP_RATIO_MAX     64'sh1E848
`define UEXP_ZERO64        64'sh0

// Settings after reset: fixed mode, -100 kvar and 100 kW in 0.01 units.
`define UEXP_DEF_Q1        32'shFFFFD8F0
`define UEXP_DEF_P1        32'sh00002710
`define UEXP_DEF_Q2        32'shFFFFD8F0
`define UEXP_DEF_P2        32'sh00002710
`define UEXP_DEF_DELAY     20'h00014
`define UEXP_DEF_REL       20'h00000
`define UEXP_DEF_GROUP     3'h1

// Power history taps for the fault log records.
`define UEXP_PRE_TRIG_MS   20
`define UEXP_PRE_FAULT_MS  200
`define UEXP_PRE_TRIG_IDX  (`UEXP_PRE_TRIG_MS / `UEXP_CYCLE_MS)
`define UEXP_PRE_FAULT_IDX (`UEXP_PRE_FAULT_MS / `UEXP_CYCLE_MS)
`define UEXP_HIST_DEPTH    (`UEXP_PRE_FAULT_IDX + 1)

`define UEXP_LOG_DEPTH     12
`define UEXP_LOG_LAST      4'hB
`define UEXP_LOG_FULL      4'hC
`define UEXP_LOG_WRAP      5'h0C

`endif

// [common/uexp_pkg.sv]
`default_nettype none
package uexp_pkg;

  typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} uexp_cond_t;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_TRIP, ST_REL, ST_BLK} uexp_state_t;
  typedef enum logic {MODE_FIXED, MODE_PDEP} uexp_mode_t;
  typedef enum logic [1:0] {EV_START, EV_TRIP, EV_BLOCK} uexp_evt_t;

  typedef struct packed {
    logic signed [31:0] p;
    logic signed [31:0] q;
  } uexp_pq_t;

  typedef struct packed {
    uexp_mode_t         mode;
    logic signed [31:0] q1;
    logic signed [31:0] p1;
    logic signed [31:0] q2;
    logic signed [31:0] p2;
    logic [19:0]        delay;
    logic [19:0]        rel_delay;
    logic [2:0]         group;
  } uexp_set_t;

  typedef struct packed {
    logic [63:0]        ts;
    uexp_evt_t          evt;
    uexp_pq_t           pre_trig;
    uexp_pq_t           fault;
    uexp_pq_t           pre_fault;
    logic signed [19:0] rem;
    logic [2:0]         group;
  } uexp_rec_t;

endpackage
`default_nettype wire

// [src/uexp_log.sv]
`include "uexp_regs.svh"
`default_nettype none
module uexp_log
  import uexp_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      wr_en,
  input  wire uexp_rec_t wr_rec,
  input  wire logic [3:0] rd_idx,
  output uexp_rec_t      rd_rec,
  output logic [3:0]     count
);

  uexp_rec_t   mem [`UEXP_LOG_DEPTH];
  logic [3:0]  wptr_q;
  logic [3:0]  count_q;
  logic [4:0]  slot;
  uexp_rec_t   rd_rec_q;

  // Entries need no reset: a slot is never shown before it has been written.
  generate
    for (genvar i = 0; i < `UEXP_LOG_DEPTH; i++)
    begin : g_entry
      always_ff @(posedge clk)
      begin
        if (wr_en && wptr_q == 4'(i))
          mem[i] <= wr_rec;
      end
    end
  endgenerate

  // The oldest record is overwritten once twelve are held.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_q  <= 4'h0;
      count_q <= 4'h0;
    end
    else if (wr_en)
    begin
      wptr_q <= (wptr_q == `UEXP_LOG_LAST) ? 4'h0 : wptr_q + 4'h1;
      if (count_q != `UEXP_LOG_FULL)
        count_q <= count_q + 4'h1;
    end
  end

  always_comb
  begin
    slot = {1'b0, wptr_q} + `UEXP_LOG_WRAP - 5'h1 - {1'b0, rd_idx};
    if (slot >= `UEXP_LOG_WRAP)
      slot = slot - `UEXP_LOG_WRAP;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_rec_q <= '0;
    else if (rd_idx < count_q)
      rd_rec_q <= mem[slot[3:0]];
    else
      rd_rec_q <= '0;
  end

  assign rd_rec = rd_rec_q;
  assign count  = count_q;

endmodule // uexp_log
`default_nettype wire

// [src/uexp_stage.sv]
// Overview of operation
// - Pick up when measured reactive power falls below the active threshold.
// - Release only when reactive power rises past 97 percent of threshold.
// - Mode selects fixed threshold or two-point power-dependent area; fixed by default.
// - First reactive setting, 0.01 kvar steps, default -100 kvar, fixed pick-up value.
// - First point active power, 0.01 kW steps, default 100 kW.
// - Second point reactive and active settings, defaults -100 kvar and 100 kW.
// - Condition read-out encodes normal, start, trip and blocked.
// - Expected operating time reported in 5 ms steps.
// - Signed remaining time to trip reported in 5 ms steps while timing.
// - Signed ratio of measured power to threshold reported in 0.01 steps.
// - Blocking input is sampled at the start of every program cycle.
// - Pick-up without blocking raises start and begins operate timing.
// - Pick-up while blocked raises blocked only, with no timing or trip.
// - Blocking during start drops start and runs release timing.
// - Trip follows start after a definite fixed operate delay.
// - Time-stamped on and off events for start, trip, block under mask.
// - Resettable counters count start, trip and blocked occurrences.
// - Each cycle with an assertion writes one record with powers to a twelve-entry rolling log.
// - New settings are applied while running without stopping the stage.
// - Forcing overrides the condition to a static setting, default normal.
`include "uexp_regs.svh"
`default_nettype none
module uexp_stage
  import uexp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             meas_valid,
  input  wire uexp_pq_t         meas,
  input  wire logic             block_in,
  input  wire logic [63:0]      timestamp,
  input  wire logic             set_load,
  input  wire uexp_set_t        set_in,
  input  wire logic             force_en,
  input  wire uexp_cond_t       force_cond,
  input  wire logic [5:0]       evt_mask,
  input  wire logic [2:0]       cnt_clear,
  input  wire logic [3:0]       log_rd_idx,
  output uexp_cond_t            cond,
  output logic                  start,
  output logic                  trip,
  output logic                  blocked,
  output logic [19:0]           expected_time,
  output logic signed [19:0]    time_remaining,
  output logic signed [19:0]    ratio,
  output logic [5:0]            evt_pulse,
  output logic [63:0]           evt_time,
  output logic [15:0]           cnt_start,
  output logic [15:0]           cnt_trip,
  output logic [15:0]           cnt_blocked,
  output uexp_rec_t             log_rec,
  output logic [3:0]            log_count
);

  function automatic logic signed [63:0] sx(input logic signed [31:0] v);
    return {{32{v[31]}}, v};
  endfunction

  logic [1:0]         rsync_q;
  logic               rst_sync_n;
  uexp_set_t          set_q;
  uexp_pq_t           meas_q;
  logic               blk_q;
  logic               tick_q;
  logic               pick_q;
  logic               pick_now;
  uexp_pq_t           hist_q [`UEXP_HIST_DEPTH];
  logic signed [63:0] dq;
  logic signed [63:0] dp;
  logic signed [63:0] den;
  logic signed [63:0] quo;
  logic signed [63:0] thr64;
  logic signed [63:0] hyst64;
  logic signed [63:0] rat64;
  uexp_state_t        state_q;
  logic [19:0]        elapsed_q;
  logic [19:0]        rel_q;
  uexp_cond_t         cond_d;
  uexp_cond_t         cond_q;
  logic [2:0]         flags;
  logic [2:0]         flags_q;
  logic [2:0]         rise;
  logic [2:0]         fall;
  logic [5:0]         evt_q;
  logic [63:0]        evt_time_q;
  logic [15:0]        cnt_q [3];
  logic [19:0]        exp_q;
  logic signed [19:0] rem_q;
  logic signed [19:0] ratio_q;
  logic [20:0]        rem_d;
  logic               log_wr;
  uexp_rec_t          log_wr_rec;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rsync_q <= 2'h0;
    else
      rsync_q <= {rsync_q[0], 1'b1};
  end
  assign rst_sync_n = rsync_q[1];

  // A setting group switch lands here and takes effect at the next program cycle
  // without disturbing the timers.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      set_q.mode      <= MODE_FIXED;
      set_q.q1        <= `UEXP_DEF_Q1;
      set_q.p1        <= `UEXP_DEF_P1;
      set_q.q2        <= `UEXP_DEF_Q2;
      set_q.p2        <= `UEXP_DEF_P2;
      set_q.delay     <= `UEXP_DEF_DELAY;
      set_q.rel_delay <= `UEXP_DEF_REL;
      set_q.group     <= `UEXP_DEF_GROUP;
    end
    else if (set_load)
      set_q <= set_in;
  end

  // Measurement and blocking are captured together so the whole cycle sees one
  // consistent snapshot.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      meas_q <= '0;
      blk_q  <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= meas_valid;
      if (meas_valid)
      begin
        meas_q <= meas;
        blk_q  <= block_in;
      end
    end
  end

  generate
    for (genvar i = 0; i < `UEXP_HIST_DEPTH; i++)
    begin : g_hist
      always_ff @(posedge clk or negedge rst_sync_n)
      begin
        if (!rst_sync_n)
          hist_q[i] <= '0;
        else if (meas_valid)
          hist_q[i] <= (i == 0) ? meas : hist_q[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  // Outside the span between the two points the line is extrapolated; equal
  // active powers fall back to the first reactive point.
  always_comb
  begin
    dq  = sx(set_q.q2) - sx(set_q.q1);
    dp  = sx(meas_q.p) - sx(set_q.p1);
    den = sx(set_q.p2) - sx(set_q.p1);
    quo = (den == `UEXP_ZERO64) ? `UEXP_ZERO64 : (dq * dp) / den;
    thr64 = (set_q.mode == MODE_PDEP) ? sx(set_q.q1) + quo : sx(set_q.q1);
    hyst64 = (thr64 * `UEXP_HYST_PCT) / `UEXP_PCT_DIV;
    rat64 = (thr64 == `UEXP_ZERO64) ? `UEXP_ZERO64 : (sx(meas_q.q) * `UEXP_PCT_DIV) / thr64;
    if (rat64 > `UEXP_RATIO_MAX)
      rat64 = `UEXP_RATIO_MAX;
    if (rat64 < -`UEXP_RATIO_MAX)
      rat64 = -`UEXP_RATIO_MAX;
    if (pick_q)
      pick_now = sx(meas_q.q) <= hyst64;
    else
      pick_now = sx(meas_q.q) < thr64;
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pick_q  <= 1'b0;
      ratio_q <= 20'sh0;
    end
    else if (tick_q)
    begin
      pick_q  <= pick_now;
      ratio_q <= rat64[19:0];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_q   <= ST_IDLE;
      elapsed_q <= 20'h0;
      rel_q     <= 20'h0;
    end
    else if (tick_q)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          elapsed_q <= 20'h0;
          if (pick_now)
            state_q <= blk_q ? ST_BLK : ST_START;
        end
        ST_START:
        begin
          if (blk_q || !pick_now)
          begin
            rel_q   <= 20'h0;
            state_q <= (set_q.rel_delay == 20'h0) ? ST_IDLE : ST_REL;
          end
          else
          begin
            elapsed_q <= elapsed_q + 20'h1;
            if (elapsed_q + 20'h1 >= set_q.delay)
              state_q <= ST_TRIP;
          end
        end
        ST_TRIP:
        begin
          if (blk_q || !pick_now)
          begin
            elapsed_q <= 20'h0;
            state_q   <= ST_IDLE;
          end
        end
        ST_REL:
        begin
          if (pick_now && !blk_q)
            state_q <= ST_START;
          else
          begin
            rel_q <= rel_q + 20'h1;
            if (rel_q + 20'h1 >= set_q.rel_delay)
            begin
              elapsed_q <= 20'h0;
              state_q   <= ST_IDLE;
            end
          end
        end
        ST_BLK:
        begin
          if (!pick_now)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_comb
  begin
    unique case (state_q)
      ST_START: cond_d = COND_START;
      ST_TRIP:  cond_d = COND_TRIP;
      ST_BLK:   cond_d = COND_BLOCKED;
      default:  cond_d = COND_NORMAL;
    endcase
    if (force_en)
      cond_d = force_cond;
    rem_d = {1'b0, set_q.delay} - {1'b0, elapsed_q};
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cond_q <= COND_NORMAL;
      exp_q  <= 20'h0;
      rem_q  <= 20'sh0;
    end
    else
    begin
      cond_q <= cond_d;
      exp_q  <= set_q.delay;
      rem_q  <= (state_q == ST_START) ? signed'(rem_d[19:0]) : 20'sh0;
    end
  end

  assign flags = {cond_q == COND_BLOCKED, cond_q == COND_TRIP,
                  cond_q == COND_START || cond_q == COND_TRIP};
  assign rise  = flags & ~flags_q;
  assign fall  = ~flags & flags_q;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      flags_q    <= 3'h0;
      evt_q      <= 6'h0;
      evt_time_q <= 64'h0;
    end
    else
    begin
      flags_q    <= flags;
      evt_q      <= {fall, rise} & evt_mask;
      evt_time_q <= timestamp;
    end
  end

  // A count that wraps restarts from zero; an occurrence in the clearing cycle
  // is kept as the first count.
  generate
    for (genvar c = 0; c < 3; c++)
    begin : g_cnt
      always_ff @(posedge clk or negedge rst_sync_n)
      begin
        if (!rst_sync_n)
          cnt_q[c] <= 16'h0;
        else if (rise[c])
          cnt_q[c] <= cnt_clear[c] ? 16'h1 : cnt_q[c] + 16'h1;
        else if (cnt_clear[c])
          cnt_q[c] <= 16'h0;
      end
    end
  endgenerate

  // Simultaneous assertions, possible only under forcing, store one record.
  always_comb
  begin
    log_wr                 = |rise;
    log_wr_rec.ts          = timestamp;
    log_wr_rec.evt         = rise[1] ? EV_TRIP : (rise[0] ? EV_START : EV_BLOCK);
    log_wr_rec.pre_trig    = hist_q[`UEXP_PRE_TRIG_IDX];
    log_wr_rec.fault       = meas_q;
    log_wr_rec.pre_fault   = hist_q[`UEXP_PRE_FAULT_IDX];
    log_wr_rec.rem         = rem_q;
    log_wr_rec.group       = set_q.group;
  end

  uexp_log u_log (
    .clk    (clk),
    .rst_n  (rst_sync_n),
    .wr_en  (log_wr),
    .wr_rec (log_wr_rec),
    .rd_idx (log_rd_idx),
    .rd_rec (log_rec),
    .count  (log_count)
  );

  assign cond           = cond_q;
  assign start          = flags_q[0];
  assign trip           = flags_q[1];
  assign blocked        = flags_q[2];
  assign expected_time  = exp_q;
  assign time_remaining = rem_q;
  assign ratio          = ratio_q;
  assign evt_pulse      = evt_q;
  assign evt_time       = evt_time_q;
  assign cnt_start      = cnt_q[0];
  assign cnt_trip       = cnt_q[1];
  assign cnt_blocked    = cnt_q[2];

endmodule // uexp_stage
`default_nettype wire

// [dv/uexp_meas_model.sv]
`default_nettype none
module uexp_meas_model
  import uexp_pkg::*;
#(
  parameter int PER = 12
)
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire uexp_pq_t pq,
  input  wire logic     blk,
  output logic          meas_valid,
  output uexp_pq_t      meas,
  output logic          block_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_q;
  always_ff @(negedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q      <= 8'h00;
      meas_valid <= 1'b0;
    end
    else
    begin
      cnt_q      <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
      meas_valid <= (cnt_q == 8'(PER - 1));
    end
  end
  // Off the strobe the lines carry junk, so a stale sample is never mistaken for a fresh one.
  assign meas     = meas_valid ? pq : ~pq;
  assign block_in = meas_valid ? blk : ~blk;
endmodule // uexp_meas_model
`default_nettype wire

// [dv/uexp_stage_checker.sv]
`default_nettype none
module uexp_stage_checker
  import uexp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        meas_valid,
  input wire logic        force_en,
  input wire logic [5:0]  evt_mask,
  input wire logic [2:0]  cnt_clear,
  input wire uexp_cond_t  cond,
  input wire logic        start,
  input wire logic        trip,
  input wire logic        blocked,
  input wire logic [5:0]  evt_pulse,
  input wire logic [15:0] cnt_start,
  input wire logic [3:0]  log_count
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // The flags are registered from the condition, so they trail it by one cycle.
  a_start_flags: assert property ($past(cond) == COND_START |-> start && !trip && !blocked)
    else $error("start condition shows wrong flags");
  a_trip_flags: assert property ($past(cond) == COND_TRIP |-> trip && start && !blocked)
    else $error("trip condition shows wrong flags");
  a_block_flags: assert property ($past(cond) == COND_BLOCKED |-> blocked && !start && !trip)
    else $error("blocked condition shows wrong flags");
  a_normal_flags: assert property ($past(cond) == COND_NORMAL |-> !(start || trip || blocked))
    else $error("normal condition shows flags");
  a_cycle_paced: assert property (!force_en && !$past(force_en) && !$past(force_en, 2) && $changed(cond)
      |-> $past(meas_valid, 3))
    else $error("condition changed without a sample");
  a_trip_after: assert property (!force_en && $rose(trip) |-> $past(start))
    else $error("trip without prior start");
  // Event pulse, counter step and log write land on the same edge as the start flag.
  a_start_event: assert property ($rose(start) && $past(evt_mask[0]) |-> evt_pulse[0])
    else $error("start event missing");
  a_start_count: assert property ($rose(start) && !$past(cnt_clear[0])
      |-> cnt_start == $past(cnt_start) + 16'h0001)
    else $error("start counter did not step");
  a_log_grows: assert property ($rose(start) && $past(log_count) < 4'hC
      |-> log_count == $past(log_count) + 4'h1)
    else $error("log did not grow");

  c_start: cover property ($rose(start));
  c_trip: cover property ($rose(trip));
  c_blocked: cover property ($rose(blocked));
endmodule // uexp_stage_checker
bind uexp_stage uexp_stage_checker i_uexp_stage_checker (.clk, .rst_n, .meas_valid, .force_en, .evt_mask,
  .cnt_clear, .cond, .start, .trip, .blocked, .evt_pulse, .cnt_start, .log_count);
`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none
module tb_top
  import uexp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clk;
  logic               rst_n;
  uexp_pq_t           pq;
  logic               blk;
  logic               meas_valid;
  uexp_pq_t           meas;
  logic               block_in;
  logic [63:0]        ts;
  logic               set_load;
  uexp_set_t          set_in;
  logic               force_en;
  uexp_cond_t         force_cond;
  logic [5:0]         evt_mask;
  logic [2:0]         cnt_clear;
  logic [3:0]         log_rd_idx;
  uexp_cond_t         cond;
  logic               start;
  logic               trip;
  logic               blocked;
  logic [19:0]        expected_time;
  logic signed [19:0] time_remaining;
  logic signed [19:0] ratio;
  logic [5:0]         evt_pulse;
  logic [63:0]        evt_time;
  logic [15:0]        cnt_start;
  logic [15:0]        cnt_trip;
  logic [15:0]        cnt_blocked;
  uexp_rec_t          log_rec;
  logic [3:0]         log_count;
  int                 errors;
  int                 samples_checked;

  uexp_meas_model #(.PER(12)) i_uexp_meas_model (.clk, .rst_n, .pq, .blk, .meas_valid, .meas, .block_in);
  uexp_stage i_uexp_stage (.clk, .rst_n, .meas_valid, .meas, .block_in, .timestamp(ts), .set_load, .set_in,
    .force_en, .force_cond, .evt_mask, .cnt_clear, .log_rd_idx, .cond, .start, .trip, .blocked, .expected_time,
    .time_remaining, .ratio, .evt_pulse, .evt_time, .cnt_start, .cnt_trip, .cnt_blocked, .log_rec, .log_count);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk)
  begin
    ts <= (rst_n === 1'b1) ? ts + 64'h1 : 64'h0;
  end

  task automatic test_done();
    $display("Checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] got);
    samples_checked++;
    if (got !== e)
    begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, e, got);
    end
  endtask

  // Returns on the third falling edge after the sample was taken, when the condition has settled.
  task automatic smp(input logic [31:0] q, input logic [31:0] p, input logic b);
    int n;
    n = 0;
    pq  <= {p, q};
    blk <= b;
    @(posedge clk);
    while (meas_valid !== 1'b1 && n < 64)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 64)
    begin
      errors++;
      $display("ERROR sample strobe expected 1 seen 0");
      test_done();
    end
    repeat (3) @(negedge clk);
  endtask

  task automatic load();
    @(negedge clk);
    set_load <= 1'b1;
    @(negedge clk);
    set_load <= 1'b0;
  endtask

  initial
  begin
    errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    pq = '0;
    blk = 1'b0;
    set_load = 1'b0;
    set_in = {MODE_FIXED, 32'shFFFFD8F0, 32'sh00002710, 32'shFFFFD8F0, 32'sh00002710, 20'h00014, 20'h00000, 3'h1};
    force_en = 1'b0;
    force_cond = COND_NORMAL;
    evt_mask = 6'h3F;
    cnt_clear = 3'h0;
    log_rd_idx = 4'h0;
    repeat (4) @(negedge clk);
    rst_n <= 1'b1;
    smp(-32'sh270F, 32'sh0, 1'b0);
    chk("cond", COND_NORMAL, cond);
    chk("expected_time", 20'h00014, expected_time);
    smp(-32'sh2711, 32'sh0, 1'b0);
    chk("cond", COND_START, cond);
    chk("ratio", 20'h00064, ratio);
    @(negedge clk);
    chk("evt_pulse", 6'h01, evt_pulse);
    chk("evt_time", ts, evt_time);
    chk("cnt_start", 16'h0001, cnt_start);
    smp(-32'sh2648, 32'sh0, 1'b0);
    chk("cond", COND_START, cond);
    smp(-32'sh2580, 32'sh0, 1'b0);
    chk("cond", COND_NORMAL, cond);
    @(negedge clk);
    chk("evt_pulse", 6'h08, evt_pulse);
    $display("Test hysteresis done");
    set_in.delay <= 20'h00003;
    set_in.group <= 3'h2;
    load();
    smp(-32'sh2EE0, 32'sh0, 1'b0);
    chk("cond", COND_START, cond);
    chk("time_remaining", 20'h00003, time_remaining);
    smp(-32'sh2EE0, 32'sh0, 1'b0);
    smp(-32'sh2EE0, 32'sh0, 1'b0);
    chk("trip", 1'b0, trip);
    chk("cond", COND_START, cond);
    smp(-32'sh2EE0, 32'sh0, 1'b0);
    chk("cond", COND_TRIP, cond);
    @(negedge clk);
    chk("evt_pulse", 6'h02, evt_pulse);
    chk("cnt_trip", 16'h0001, cnt_trip);
    chk("expected_time", 20'h00003, expected_time);
    smp(-32'sh1388, 32'sh0, 1'b0);
    chk("cond", COND_NORMAL, cond);
    $display("Test trip done");
    smp(-32'sh2EE0, 32'sh0, 1'b1);
    chk("cond", COND_BLOCKED, cond);
    @(negedge clk);
    chk("evt_pulse", 6'h04, evt_pulse);
    chk("cnt_blocked", 16'h0001, cnt_blocked);
    for (int i = 0; i < 4; i++)
    begin
      smp(-32'sh2EE0, 32'sh0, 1'b0);
      chk("trip", 1'b0, trip);
    end
    chk("log_count", 4'h4, log_count);
    chk("log_evt", EV_BLOCK, log_rec.evt);
    chk("log_group", 3'h2, log_rec.group);
    chk("log_fault", {32'h0, -32'sh2EE0}, log_rec.fault);
    log_rd_idx <= 4'h1;
    @(negedge clk);
    chk("log_evt", EV_TRIP, log_rec.evt);
    log_rd_idx <= 4'h4;
    @(negedge clk);
    chk("log_ts", 64'h0, log_rec.ts);
    log_rd_idx <= 4'h0;
    smp(-32'sh1388, 32'sh0, 1'b0);
    $display("Test blocking done");
    smp(-32'sh2EE0, 32'sh0, 1'b0);
    smp(-32'sh2EE0, 32'sh0, 1'b1);
    // The start flag trails the condition by one cycle.
    @(negedge clk);
    chk("start", 1'b0, start);
    for (int i = 0; i < 3; i++)
    begin
      smp(-32'sh2EE0, 32'sh0, 1'b1);
      chk("trip", 1'b0, trip);
    end
    smp(-32'sh1388, 32'sh0, 1'b0);
    $display("Test late block done");
    set_in.mode <= MODE_PDEP;
    set_in.p1 <= 32'sh0;
    set_in.q2 <= -32'sh4E20;
    load();
    smp(-32'sh36B0, 32'sh1388, 1'b0);
    chk("cond", COND_NORMAL, cond);
    smp(-32'sh3E80, 32'sh1388, 1'b0);
    chk("cond", COND_START, cond);
    chk("ratio", 20'h0006A, ratio);
    smp(-32'sh1388, 32'sh1388, 1'b0);
    $display("Test power dependent done");
    @(negedge clk);
    cnt_clear <= 3'h7;
    @(negedge clk);
    cnt_clear <= 3'h0;
    chk("cnt_start", 16'h0000, cnt_start);
    chk("cnt_trip", 16'h0000, cnt_trip);
    chk("cnt_blocked", 16'h0000, cnt_blocked);
    $display("Test counter clear done");
    for (int i = 0; i < 4; i++)
    begin
      force_cond <= uexp_cond_t'(i);
      force_en <= 1'b1;
      smp(-32'sh1388, 32'sh1388, 1'b0);
      chk("forced cond", 64'(i), cond);
    end
    force_en <= 1'b0;
    smp(-32'sh1388, 32'sh1388, 1'b0);
    chk("cond", COND_NORMAL, cond);
    $display("Test forcing done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
